// file: src/smr_consts.vh
/*
 holds the constants of the message receive and report block: codes, steps,
 command codes, clock rate, bus phases, queue depth. assumes inclusion by bare name, 20 MHz clock.
*/
`ifndef SMR_CONSTS_VH
`define SMR_CONSTS_VH
`define SMR_CLK_MHZ 20
// report codes
`define SMR_C_RESET 8'h01
`define SMR_C_HOSTPAR 8'h22
`define SMR_C_SCSIPAR 8'h24
`define SMR_C_TIMEOUT 8'h2c
`define SMR_C_BUSFREE 8'h31
`define SMR_C_PHASECHG 8'h32
`define SMR_C_BADPHASE 8'h54
`define SMR_C_STATUS 8'h56
`define SMR_C_STATBLK 8'h5e
`define SMR_C_NORMAL 8'h60
`define SMR_C_DOUBLE 8'h64
`define SMR_C_REJECT 8'h65
`define SMR_C_MSGBLK 8'h6c
`define SMR_C_FREEPRE 8'h70
// step values
`define SMR_S_BEFORE 8'h00
`define SMR_S_DURING 8'h01
`define SMR_S_DONE 8'h02
// command codes
`define SMR_CMD_MSGRX 8'h17
`define SMR_CMD_SEL 8'h20
`define SMR_CMD_SELATN 8'h21
`define SMR_CMD_XFER 8'h18
`define SMR_CMD_TGT 8'h40
`define SMR_CMD_DISC 8'h00
// scsi bus phases (msg, c/d, i/o)
`define SMR_PH_MSGIN 3'h7
`define SMR_PH_STATUS 3'h3
// report queue depth
`define SMR_QDEPTH 4
`define SMR_QAW 2
`endif

// file: src/smr_report_mem.v
/*
 holds the small report queue memory: code and step words, registered read.
 assumes one writer and one reader in the same clock domain.
*/
module smr_report_mem (
  // clocking
  input wire sys_clk,
  input wire clk_en,
  // write side
  input wire wr_en,
  input wire [1:0] wr_addr,
  input wire [15:0] wr_data,
  // read side
  input wire [1:0] rd_addr,
  output reg [15:0] rd_data
);
  reg [15:0] mem [0:3];

  // memory array has no reset; contents are qualified by queue pointers
  always @(posedge sys_clk)
  begin
    if (clk_en)
    begin
      if (wr_en)
        mem[wr_addr] <= wr_data;
      rd_data <= mem[rd_addr];
    end
  end
endmodule

// file: src/smr_skid_buf.v
/*
 holds a two-entry buffer with valid/ready on both sides for received bytes.
 assumes the drain side may stall for any number of cycles.
*/
module smr_skid_buf (
  // clocking and reset
  input wire sys_clk,
  input wire rst_n,
  input wire clk_en,
  // fill side
  input wire in_valid,
  output wire in_ready,
  input wire [7:0] in_data,
  // drain side
  output wire out_valid,
  input wire out_ready,
  output reg [7:0] out_data,
  // occupancy
  output wire buf_empty
);
  reg [7:0] hold_r;
  reg [1:0] cnt_r;

  assign in_ready = (cnt_r != 2'd2);
  assign out_valid = (cnt_r != 2'd0);
  assign buf_empty = (cnt_r == 2'd0);

  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_r <= 2'd0;
      hold_r <= 8'h00;
      out_data <= 8'h00;
    end
    else if (clk_en)
    begin
      case ({in_valid && in_ready, out_valid && out_ready})
        2'b10:
        begin
          if (cnt_r == 2'd0)
            out_data <= in_data;
          else
            hold_r <= in_data;
          cnt_r <= cnt_r + 2'd1;
        end
        2'b01:
        begin
          out_data <= hold_r;
          cnt_r <= cnt_r - 2'd1;
        end
        2'b11:
        begin
          if (cnt_r == 2'd1)
            out_data <= in_data;
          else
          begin
            out_data <= hold_r;
            hold_r <= in_data;
          end
        end
        default:
          cnt_r <= cnt_r;
      endcase
    end
  end
endmodule

// file: src/smr_msg_receive.v
/*
 holds the message receive command engine of the initiator and its
 completion and error reporting: each outcome becomes a code/step report
 queued to the host with an interrupt.
 assumes scsi pins are asynchronous (two-flop synchronised here), host
 command port and buffer drain are on sys_clk.
*/
// Operation
// - reset before transfer posts 01h step 00h
// - reset during receive stops, posts 01h/01h
// - parity error: finish all bytes, post 24h
// - req/ack timeout ends command, posts 2ch
// - bus free mid receive posts 31h/01h
// - phase change mid receive posts 32h/01h
// - first req not message-in posts 54h
// - auto receive status first: take byte, 56h
// - auto receive status, buffer busy: 5eh
// - zero byte count refused, posts 65h/01h
// - unread buffer at first req posts 6ch/01h
// - bus free before reception posts 70h/00h
// - manual ack, free with ack posts 31h/00h
// - second command: first result, then 64h
// - pending idle source first, then 64h, for a command answered at once
// - target-only or undefined command posts 65h/00h
// - nexus order violations post 65h/00h
// - host register parity error posts 22h/00h
module smr_msg_receive (
  // clocking and reset
  input wire sys_clk,
  input wire rst_n,
  input wire clk_en,
  // host command port
  input wire cmd_valid,
  input wire [7:0] cmd_code,
  input wire [7:0] byte_count,
  input wire auto_rx_en,
  input wire manual_ack_mode,
  input wire reg_par_err,
  input wire nexus_up,
  // scsi bus pins (asynchronous)
  input wire scsi_rst,
  input wire scsi_bsy,
  input wire scsi_sel,
  input wire scsi_req,
  input wire [2:0] scsi_phase,
  input wire [7:0] scsi_data,
  input wire scsi_par_ok,
  output reg scsi_ack,
  // req/ack timeout in cycles, zero disables
  input wire [15:0] req_timeout,
  // received byte stream
  output wire rx_valid,
  input wire rx_ready,
  output wire [7:0] rx_data,
  // report to host
  output wire irq,
  output wire [7:0] rpt_code,
  output wire [7:0] rpt_step,
  input wire rpt_ack,
  output wire busy
);
  `include "smr_consts.vh"

  localparam ST_IDLE = 3'd0;
  localparam ST_WAIT = 3'd1;
  localparam ST_ACK = 3'd2;
  localparam ST_REL = 3'd3;
  localparam ST_HOLD = 3'd4;

  // two-flop synchronisers for every scsi pin
  reg [15:0] s1_r;
  reg [15:0] s2_r;
  wire [15:0] pins = {scsi_rst, scsi_bsy, scsi_sel, scsi_req, scsi_phase,
                      scsi_data, scsi_par_ok};
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_r <= 16'h0000;
      s2_r <= 16'h0000;
    end
    else if (clk_en)
    begin
      s1_r <= pins;
      s2_r <= s1_r;
    end
  end
  wire b_rst = s2_r[15];
  wire b_free = !s2_r[14] && !s2_r[13];
  wire b_req = s2_r[12];
  wire [2:0] b_ph = s2_r[11:9];
  wire [7:0] b_dat = s2_r[8:1];

  reg [2:0] st_r;
  reg [7:0] left_r;
  reg first_r;
  reg par_r;
  reg [15:0] tmo_r;
  reg dbl_r;
  reg pend_r;
  reg [7:0] byte_r;

  // received bytes enter the two-entry buffer
  wire buf_in_ready;
  wire buf_empty;
  reg buf_push;
  smr_skid_buf u_buf (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .in_valid(buf_push),
    .in_ready(buf_in_ready),
    .in_data(byte_r),
    .out_valid(rx_valid),
    .out_ready(rx_ready),
    .out_data(rx_data),
    .buf_empty(buf_empty)
  );

  // report queue
  reg [2:0] qcnt_r;
  reg [1:0] wp_r;
  reg [1:0] rp_r;
  reg [1:0] q_wr;
  reg [15:0] q_d0;
  reg [15:0] q_d1;
  wire [15:0] q_rd;
  wire q_pop = rpt_ack && (qcnt_r != 3'd0);
  wire [1:0] rp_nxt = q_pop ? rp_r + 2'd1 : rp_r;
  smr_report_mem u_mem (
    .sys_clk(sys_clk),
    .clk_en(clk_en),
    .wr_en(q_wr != 2'd0),
    .wr_addr(wp_r),
    .wr_data(q_wr[0] ? q_d0 : q_d1),
    .rd_addr(rp_nxt),
    .rd_data(q_rd)
  );
  reg [15:0] second_r;
  reg second_v_r;
  assign rpt_code = q_rd[15:8];
  assign rpt_step = q_rd[7:0];
  reg wr_fresh_r;
  // report and its interrupt stand until the host acknowledges, except that a write at the queue depth replaces the report
  assign irq = (qcnt_r != 3'd0) && !wr_fresh_r;
  assign busy = (st_r != ST_IDLE);

  // command decode
  wire is_msg = cmd_code == `SMR_CMD_MSGRX;
  wire is_sel = cmd_code == `SMR_CMD_SEL || cmd_code == `SMR_CMD_SELATN;
  wire is_xfer = cmd_code == `SMR_CMD_XFER;
  wire is_disc = cmd_code == `SMR_CMD_DISC;
  wire cmd_ok = is_msg || is_sel || is_xfer || is_disc;

  reg [15:0] rep_nxt;
  reg rep_go;
  reg [2:0] st_nxt;
  always @*
  begin
    rep_go = 1'b0;
    rep_nxt = 16'h0000;
    st_nxt = st_r;
    buf_push = 1'b0;
    case (st_r)
      ST_IDLE:
      begin
        if (cmd_valid)
        begin
          rep_go = 1'b1;
          st_nxt = ST_IDLE;
          if (reg_par_err)
            rep_nxt = {`SMR_C_HOSTPAR, `SMR_S_BEFORE};
          else if (!cmd_ok || cmd_code[7:6] == 2'b01)
            rep_nxt = {`SMR_C_REJECT, `SMR_S_BEFORE};
          else if (((is_msg || is_xfer) && !nexus_up) || (is_sel && nexus_up))
            rep_nxt = {`SMR_C_REJECT, `SMR_S_BEFORE};
          else if (!is_msg)
            rep_nxt = {`SMR_C_NORMAL, `SMR_S_DURING};
          else if (b_rst)
            rep_nxt = {`SMR_C_RESET, `SMR_S_BEFORE};
          else if (b_free)
            rep_nxt = {`SMR_C_FREEPRE, `SMR_S_BEFORE};
          else if (byte_count == 8'h00)
            rep_nxt = {`SMR_C_REJECT, `SMR_S_DURING};
          else
          begin
            rep_go = 1'b0;
            st_nxt = ST_WAIT;
          end
        end
        else if (manual_ack_mode && scsi_ack && b_free)
        begin
          rep_go = 1'b1;
          rep_nxt = {`SMR_C_BUSFREE, `SMR_S_BEFORE};
        end
      end
      ST_WAIT, ST_ACK, ST_REL:
      begin
        // reset, free, timeout end the command at once
        if (b_rst)
        begin
          rep_go = 1'b1;
          rep_nxt = {`SMR_C_RESET, `SMR_S_DURING};
          st_nxt = ST_IDLE;
        end
        else if (b_free)
        begin
          rep_go = 1'b1;
          rep_nxt = {`SMR_C_BUSFREE, `SMR_S_DURING};
          st_nxt = ST_IDLE;
        end
        else if (req_timeout != 16'h0000 && tmo_r >= req_timeout)
        begin
          rep_go = 1'b1;
          rep_nxt = {`SMR_C_TIMEOUT, `SMR_S_DURING};
          st_nxt = ST_IDLE;
        end
        else if (st_r == ST_WAIT && b_req)
        begin
          if (first_r && b_ph != `SMR_PH_MSGIN)
          begin
            rep_go = 1'b1;
            st_nxt = ST_IDLE;
            if (auto_rx_en && b_ph == `SMR_PH_STATUS && !buf_empty)
              rep_nxt = {`SMR_C_STATBLK, `SMR_S_DURING};
            else if (auto_rx_en && b_ph == `SMR_PH_STATUS && buf_in_ready)
            begin
              rep_go = 1'b0;
              st_nxt = ST_ACK;
            end
            else
              rep_nxt = {`SMR_C_BADPHASE, `SMR_S_DURING};
          end
          else if (!first_r && b_ph != `SMR_PH_MSGIN)
          begin
            rep_go = 1'b1;
            rep_nxt = {`SMR_C_PHASECHG, `SMR_S_DURING};
            st_nxt = ST_IDLE;
          end
          else if (first_r && !buf_empty)
          begin
            // checked at first req so the status path can still report 5eh
            rep_go = 1'b1;
            rep_nxt = {`SMR_C_MSGBLK, `SMR_S_DURING};
            st_nxt = ST_IDLE;
          end
          else if (buf_in_ready)
            st_nxt = ST_ACK;
        end
        else if (st_r == ST_ACK)
        begin
          buf_push = 1'b1;
          st_nxt = ST_REL;
        end
        else if (st_r == ST_REL && !b_req)
        begin
          if (b_ph == `SMR_PH_STATUS && first_r)
          begin
            rep_go = 1'b1;
            rep_nxt = {`SMR_C_STATUS, `SMR_S_DURING};
            st_nxt = ST_IDLE;
          end
          else if (left_r == 8'h01)
          begin
            rep_go = 1'b1;
            st_nxt = ST_IDLE;
            if (par_r)
              rep_nxt = {`SMR_C_SCSIPAR, `SMR_S_DURING};
            else
              rep_nxt = {`SMR_C_NORMAL, `SMR_S_DONE};
          end
          else
            st_nxt = ST_WAIT;
        end
      end
      default:
        st_nxt = ST_IDLE;
    endcase
  end

  // a busy-time command, or one answered at once over a pending idle report, queues a 64h after
  wire dbl_now = cmd_valid && st_r != ST_IDLE;
  wire pend_now = cmd_valid && st_r == ST_IDLE && (qcnt_r != 3'd0);

  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r <= ST_IDLE;
      left_r <= 8'h00;
      first_r <= 1'b0;
      par_r <= 1'b0;
      tmo_r <= 16'h0000;
      dbl_r <= 1'b0;
      pend_r <= 1'b0;
      byte_r <= 8'h00;
      scsi_ack <= 1'b0;
      qcnt_r <= 3'd0;
      wp_r <= 2'd0;
      rp_r <= 2'd0;
      q_wr <= 2'd0;
      q_d0 <= 16'h0000;
      q_d1 <= 16'h0000;
      second_r <= 16'h0000;
      second_v_r <= 1'b0;
      wr_fresh_r <= 1'b0;
    end
    else if (clk_en)
    begin
      st_r <= st_nxt;
      tmo_r <= (st_nxt != st_r || st_r == ST_IDLE) ? 16'h0000 : tmo_r + 16'h0001;
      if (st_r == ST_IDLE && st_nxt == ST_WAIT)
      begin
        left_r <= byte_count;
        first_r <= 1'b1;
        par_r <= 1'b0;
      end
      if (st_nxt == ST_ACK && st_r == ST_WAIT)
      begin
        byte_r <= b_dat;
        par_r <= par_r | !s2_r[0];
        scsi_ack <= 1'b1;
      end
      if (st_r == ST_ACK)
        first_r <= first_r && b_ph == `SMR_PH_STATUS;
      if (st_r == ST_REL && !b_req)
      begin
        left_r <= left_r - 8'h01;
        if (!manual_ack_mode)
          scsi_ack <= 1'b0;
      end
      if (b_free)
        scsi_ack <= 1'b0;
      if (dbl_now)
        dbl_r <= 1'b1;
      // the 64h report goes in behind the first result
      q_wr <= 2'd0;
      if (rep_go)
      begin
        q_d0 <= rep_nxt;
        q_wr <= 2'b01;
        if (dbl_r || dbl_now || pend_now)
        begin
          second_r <= {`SMR_C_DOUBLE, `SMR_S_BEFORE};
          second_v_r <= 1'b1;
          dbl_r <= 1'b0;
        end
      end
      else if (second_v_r)
      begin
        q_d1 <= second_r;
        q_wr <= 2'b10;
        second_v_r <= 1'b0;
      end
      if (q_wr != 2'd0)
        wp_r <= wp_r + 2'd1;
      // at the queue depth the count holds at 4, but the write still lands and wp_r advances over the oldest entry
      qcnt_r <= qcnt_r + ((q_wr != 2'd0 && qcnt_r != 3'd4) ? 3'd1 : 3'd0)
                - (q_pop ? 3'd1 : 3'd0);
      rp_r <= rp_nxt;
      wr_fresh_r <= q_pop || (q_wr != 2'd0 && qcnt_r == 3'd0);
    end
  end
endmodule

// file: dv/smr_msg_receive_properties.sv
/*
 checker for the message receive block: report holding and command outcomes.
 assumes clk_en held high, so every window below counts real cycles.
*/
`include "smr_consts.vh"
module smr_mr_chk (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // host side
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic [7:0] byte_count,
  input wire logic reg_par_err,
  input wire logic nexus_up,
  input wire logic busy,
  // report
  input wire logic irq,
  input wire logic [7:0] rpt_code,
  input wire logic [7:0] rpt_step,
  input wire logic rpt_ack,
  // scsi
  input wire logic scsi_req,
  input wire logic scsi_ack,
  input wire logic scsi_rst
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  wire idle = !busy && !irq;
  wire new_rx = idle && cmd_valid && !reg_par_err && cmd_code == `SMR_CMD_MSGRX;

  a_irq_held: assert property (irq && !rpt_ack |=> irq)
    else $error("irq dropped without ack");
  a_rpt_steady: assert property (irq && !rpt_ack |=> $stable({rpt_code, rpt_step}))
    else $error("report changed while presented");
  a_ack_drops: assert property (irq && rpt_ack |=> !irq)
    else $error("irq stayed after ack");
  a_zero_cnt: assert property (new_rx && nexus_up && byte_count == 8'h00
    |-> ##[1:6] (irq && rpt_code == 8'h65 && rpt_step == 8'h01))
    else $error("zero count not refused");
  a_host_par: assert property (idle && cmd_valid && reg_par_err
    |-> ##[1:6] (irq && rpt_code == 8'h22 && rpt_step == 8'h00))
    else $error("register parity not reported");
  a_tgt_cmd: assert property (idle && cmd_valid && !reg_par_err && cmd_code[7:6] == 2'b01
    |-> ##[1:6] (irq && rpt_code == 8'h65 && rpt_step == 8'h00))
    else $error("target command not rejected");
  a_no_nexus: assert property (new_rx && !nexus_up && byte_count != 8'h00
    |-> ##[1:6] (irq && rpt_code == 8'h65 && rpt_step == 8'h00))
    else $error("transfer without nexus not rejected");
  a_rst_stop: assert property (busy && scsi_rst |-> ##[1:8] (irq && rpt_code == 8'h01))
    else $error("bus reset not reported");
  a_req_ack: assert property ($rose(scsi_ack) |-> $past(scsi_req, 2))
    else $error("ack without request");

  cover property (irq && rpt_code == 8'h60);
  cover property (irq && rpt_code == 8'h24);
  cover property (irq && rpt_code == 8'h64);
endmodule

bind smr_msg_receive smr_mr_chk chk_u (.sys_clk(sys_clk), .rst_n(rst_n),
  .cmd_valid(cmd_valid), .cmd_code(cmd_code), .byte_count(byte_count),
  .reg_par_err(reg_par_err), .nexus_up(nexus_up), .busy(busy), .irq(irq),
  .rpt_code(rpt_code), .rpt_step(rpt_step), .rpt_ack(rpt_ack),
  .scsi_req(scsi_req), .scsi_ack(scsi_ack), .scsi_rst(scsi_rst));

// file: dv/smr_tgt_model.sv
/*
 behavioural scsi target: one byte per req/ack, phase and parity per byte.
 assumes the bench calls put and may drop busy directly.
*/
module smr_tgt_model (
  // clock
  input wire logic sys_clk,
  // initiator answer
  input wire logic scsi_ack,
  // target lines
  output logic scsi_req,
  output logic scsi_bsy,
  output logic [2:0] scsi_phase,
  output logic [7:0] scsi_data,
  output logic scsi_par_ok
);
  timeunit 1ns;
  timeprecision 1ns;
  int acks = 0;
  initial
  begin
    scsi_req = 1'b0;
    scsi_bsy = 1'b1;
    scsi_phase = 3'h7;
    scsi_data = 8'h00;
    scsi_par_ok = 1'b1;
  end
  // gives up after 40 cycles, as a refused byte never gets an ack
  task automatic put(input logic [2:0] ph, input logic [7:0] d, input logic ok);
    int i;
    @(negedge sys_clk);
    scsi_phase = ph;
    scsi_data = d;
    scsi_par_ok = ok;
    @(negedge sys_clk);
    scsi_req = 1'b1;
    for (i = 0; i < 40 && scsi_ack !== 1'b1; i++)
      @(negedge sys_clk);
    if (scsi_ack === 1'b1)
      acks++;
    scsi_req = 1'b0;
    scsi_data = ~d;
    scsi_par_ok = ~ok;
    for (i = 0; i < 40 && scsi_ack !== 1'b0; i++)
      @(negedge sys_clk);
  endtask
endmodule

// file: dv/smr_msg_receive_tb.sv
/*
 bench for the message receive block: each outcome code driven and judged.
 assumes the target model drives the bus; inputs move on falling edges.
*/
`include "smr_consts.vh"
module smr_msg_receive_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 0, rst_n = 0, cmd_valid = 0, auto_rx_en = 0, reg_par_err = 0;
  logic nexus_up = 1, scsi_rst = 0, rx_ready = 0, rpt_ack = 0, manual_ack = 0;
  logic [7:0] cmd_code = 0, byte_count = 1;
  logic [15:0] req_timeout = 0, r;
  logic scsi_req, scsi_bsy, scsi_par_ok, scsi_ack, rx_valid, irq, busy;
  logic [2:0] scsi_phase;
  logic [7:0] scsi_data, rx_data, rpt_code, rpt_step;
  int mismatches = 0, samples_checked = 0, a0;
  always #25 sys_clk = ~sys_clk;
  smr_msg_receive dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(1'b1),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .byte_count(byte_count),
    .auto_rx_en(auto_rx_en), .manual_ack_mode(manual_ack), .reg_par_err(reg_par_err),
    .nexus_up(nexus_up), .scsi_rst(scsi_rst), .scsi_bsy(scsi_bsy), .scsi_sel(1'b0),
    .scsi_req(scsi_req), .scsi_phase(scsi_phase), .scsi_data(scsi_data),
    .scsi_par_ok(scsi_par_ok), .scsi_ack(scsi_ack), .req_timeout(req_timeout),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data), .irq(irq),
    .rpt_code(rpt_code), .rpt_step(rpt_step), .rpt_ack(rpt_ack), .busy(busy));
  smr_tgt_model tgt_u (.sys_clk(sys_clk), .scsi_ack(scsi_ack), .scsi_req(scsi_req),
    .scsi_bsy(scsi_bsy), .scsi_phase(scsi_phase), .scsi_data(scsi_data),
    .scsi_par_ok(scsi_par_ok));

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic go(input logic [7:0] c);
    @(negedge sys_clk);
    cmd_code = c;
    cmd_valid = 1;
    @(negedge sys_clk);
    cmd_valid = 0;
  endtask
  // waits for the report, keeps it in r, then pops it
  task automatic rpt;
    int i;
    for (i = 0; i < 300 && irq !== 1'b1; i++)
      @(negedge sys_clk);
    r = {rpt_code, rpt_step};
    rpt_ack = 1;
    @(negedge sys_clk);
    rpt_ack = 0;
    @(negedge sys_clk);
  endtask
  task automatic rd(input logic [7:0] e);
    int i;
    for (i = 0; i < 50 && rx_valid !== 1'b1; i++)
      @(negedge sys_clk);
    chk({8'h00, rx_data}, {8'h00, e});
    rx_ready = 1;
    @(negedge sys_clk);
    rx_ready = 0;
  endtask

  // receiver stalls, so the two bytes fill the buffer
  task automatic t_normal;
    byte_count = 8'h02;
    go(`SMR_CMD_MSGRX);
    tgt_u.put(3'h7, 8'h35, 1);
    tgt_u.put(3'h7, 8'hca, 1);
    rpt();
    chk(r, 16'h6002);
    auto_rx_en = 1;
    go(`SMR_CMD_MSGRX);
    tgt_u.put(3'h3, 8'h5b, 1);
    rpt();
    chk(r, 16'h5e01);
    auto_rx_en = 0;
    go(`SMR_CMD_MSGRX);
    tgt_u.put(3'h7, 8'h5a, 1);
    rpt();
    chk(r, 16'h6c01);
    rd(8'h35);
    rd(8'hca);
    chk({15'h0, rx_valid}, 16'h0000);
    $display("normal done");
  endtask
  task automatic t_parity;
    a0 = tgt_u.acks;
    go(`SMR_CMD_MSGRX);
    tgt_u.put(3'h7, 8'h11, 0);
    tgt_u.put(3'h7, 8'h22, 1);
    rpt();
    chk(r, 16'h2401);
    chk(16'(tgt_u.acks - a0), 16'h0002);
    rd(8'h11);
    rd(8'h22);
    $display("parity done");
  endtask
  task automatic t_abort;
    req_timeout = 16'd30;
    go(`SMR_CMD_MSGRX);
    tgt_u.put(3'h7, 8'h01, 1);
    rpt();
    chk(r, 16'h2c01);
    req_timeout = 0;
    rd(8'h01);
    go(`SMR_CMD_MSGRX);
    tgt_u.put(3'h7, 8'h02, 1);
    tgt_u.scsi_bsy = 0;
    rpt();
    chk(r, 16'h3101);
    tgt_u.scsi_bsy = 1;
    rd(8'h02);
    go(`SMR_CMD_MSGRX);
    tgt_u.put(3'h7, 8'h03, 1);
    tgt_u.put(3'h1, 8'h04, 1);
    rpt();
    chk(r, 16'h3201);
    rd(8'h03);
    $display("abort done");
  endtask
  task automatic t_phase;
    byte_count = 8'h01;
    go(`SMR_CMD_MSGRX);
    tgt_u.put(3'h1, 8'h05, 1);
    rpt();
    chk(r, 16'h5401);
    auto_rx_en = 1;
    go(`SMR_CMD_MSGRX);
    tgt_u.put(3'h3, 8'h02, 1);
    rpt();
    chk(r, 16'h5601);
    auto_rx_en = 0;
    rd(8'h02);
    $display("phase done");
  endtask
  task automatic t_bus;
    scsi_rst = 1;
    // pins reach the design two edges late
    repeat (3) @(negedge sys_clk);
    go(`SMR_CMD_MSGRX);
    rpt();
    chk(r, 16'h0100);
    scsi_rst = 0;
    repeat (10) @(negedge sys_clk);
    byte_count = 8'h02;
    go(`SMR_CMD_MSGRX);
    tgt_u.put(3'h7, 8'h06, 1);
    scsi_rst = 1;
    rpt();
    chk(r, 16'h0101);
    scsi_rst = 0;
    rd(8'h06);
    tgt_u.scsi_bsy = 0;
    repeat (3) @(negedge sys_clk);
    go(`SMR_CMD_MSGRX);
    rpt();
    chk(r, 16'h7000);
    tgt_u.scsi_bsy = 1;
    repeat (3) @(negedge sys_clk);
    // manual release: ack outlives the transfer until the bus goes free
    manual_ack = 1;
    byte_count = 8'h01;
    go(`SMR_CMD_MSGRX);
    tgt_u.put(3'h7, 8'h08, 1);
    rpt();
    chk(r, 16'h6002);
    tgt_u.scsi_bsy = 0;
    rpt();
    chk(r, 16'h3100);
    tgt_u.scsi_bsy = 1;
    repeat (3) @(negedge sys_clk);
    manual_ack = 0;
    rd(8'h08);
    $display("bus done");
  endtask
  task automatic t_refuse;
    logic [7:0] cs [3] = '{8'h40, 8'hff, `SMR_CMD_SEL};
    byte_count = 8'h00;
    go(`SMR_CMD_MSGRX);
    rpt();
    chk(r, 16'h6501);
    byte_count = 8'h01;
    foreach (cs[i])
    begin
      go(cs[i]);
      rpt();
      chk(r, 16'h6500);
    end
    nexus_up = 0;
    go(`SMR_CMD_MSGRX);
    rpt();
    chk(r, 16'h6500);
    nexus_up = 1;
    reg_par_err = 1;
    go(`SMR_CMD_MSGRX);
    rpt();
    chk(r, 16'h2200);
    reg_par_err = 0;
    $display("refuse done");
  endtask
  // second command lands while the first is still running
  task automatic t_double;
    go(`SMR_CMD_MSGRX);
    @(negedge sys_clk);
    go(`SMR_CMD_DISC);
    tgt_u.put(3'h7, 8'h07, 1);
    rpt();
    chk(r, 16'h6002);
    rpt();
    chk(r, 16'h6400);
    rd(8'h07);
    go(8'hff);
    go(8'hff);
    rpt();
    chk(r, 16'h6500);
    rpt();
    chk(r, 16'h6500);
    rpt();
    chk(r, 16'h6400);
    $display("double done");
  endtask

  task automatic wrap_up;
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    #(40000 * 50);
    mismatches++;
    wrap_up();
  end
  initial
  begin
    repeat (8) @(negedge sys_clk);
    rst_n = 1;
    // synchroniser still reads the bus as free for two edges
    repeat (3) @(negedge sys_clk);
    t_normal();
    t_parity();
    t_abort();
    t_phase();
    t_bus();
    t_refuse();
    t_double();
    wrap_up();
  end
endmodule
